// ===== pkg/cssr_consts.svh
// Register map, field positions and reset values of the status/control bank
`ifndef CSSR_CONSTS_SVH
`define CSSR_CONSTS_SVH
`define CSSR_ADDR_W     7
`define CSSR_DATA_W     8
`define CSSR_BIAS_W     6
`define CSSR_CNT_W      5
`define CSSR_CNT_ADDR   5'h07
`define CSSR_CNT_LAST   5'h0F
`define CSSR_CNT_DATA   5'h08
`define CSSR_CNT_DONE   5'h10
`define CSSR_A_BIAS_RES 7'h4E
`define CSSR_A_DIV_INIT 7'h55
`define CSSR_A_SYNTH_LOCK_RESTART   7'h56
`define CSSR_A_CAL_EDGE 7'h57
`define CSSR_A_STATUS   7'h5A
`define CSSR_A_BIAS_MAN 7'h63
`define CSSR_B_CMD      7
`define CSSR_B_EDGE     0
`define CSSR_B_MAN_EN   0
`define CSSR_B_MAN_LO   1
`define CSSR_B_MAN_HI   6
`define CSSR_B_LAT      0
`define CSSR_B_NOW      1
`define CSSR_B_REF      2
`define CSSR_B_CAL      3
`define CSSR_B_IE       4
`define CSSR_LAT_RST    1'b1
`define CSSR_EDGE_RST   1'b0
`define CSSR_BIAS_RST   6'h00
`endif

// ===== pkg/cssr_pkg.sv
// Types shared by the status/control bank
`default_nettype none
package cssr_pkg;
  typedef struct packed {
    logic holdover_state;
    logic synth_cal_active;
    logic ref_present;
  } cssr_stat_t;
  typedef struct packed {
    logic       stb;
    logic [6:0] addr;
    logic [7:0] data;
  } cssr_wr_t;
  typedef enum logic [1:0] {
    CSSR_IDLE = 2'b00,
    CSSR_HEAD = 2'b01,
    CSSR_BODY = 2'b10,
    CSSR_END  = 2'b11
  } cssr_state_t;
endpackage
`default_nettype wire

// ===== rtl/cssr_regs.sv
// Serial-port status and control register bank
`timescale 1ns/100ps
`default_nettype none
`include "cssr_consts.svh"
// Behaviour
// - Latched holdover reads 0 after holdover entry
// - Write 1 clears latch and interrupt
// - Calibration status 1 while calibrating
// - Reference status 1 when reference present
// - Momentary holdover reads 0 in holdover
// - Divider init command self-clearing pulse
// - Synth_lock_restart command self-clearing pulse
// - Bias calibration start clears when done
// - Edge select picks readback clock edge
// - Bias result holds latest calibration
// - Manual bias field read/write, resets zero
// - Override enable selects manual bias
// - Enabled latched holdover drives alert low
module cssr_regs (
  input  wire logic                   clock,
  input  wire logic                   nrst,
  input  wire logic                   spi_sclk,
  input  wire logic                   spi_cs_n,
  input  wire logic                   spi_sdi,
  output logic                        spi_sdo,
  output logic                        spi_sdo_oe,
  input  wire cssr_pkg::cssr_stat_t   stat_in,
  input  wire logic                   bias_cal_done,
  input  wire logic [5:0]             bias_cal_value,
  output logic                        divider_init,
  output logic                        synth_lock_restart,
  output logic                        bias_cal_start,
  output logic                        readback_edge_sel,
  output logic [5:0]                  bias_effective,
  output logic                        alert_out_n
);
  function automatic logic wr_hit(
    input cssr_pkg::cssr_wr_t w,
    input logic [6:0]         a,
    input int                 b
  );
    wr_hit = w.stb && (w.addr == a) && w.data[b];
  endfunction
  logic [2:0]              sclk_s_q;
  logic [1:0]              cs_s_q;
  logic [1:0]              sdi_s_q;
  cssr_pkg::cssr_stat_t    st1_q;
  cssr_pkg::cssr_stat_t    st_q;
  logic                    rise;
  logic                    fall;
  logic                    cs_act;
  logic                    sdi;
  cssr_pkg::cssr_state_t   state_q;
  logic [4:0]              cnt_q;
  logic [6:0]              sh_q;
  logic                    rd_q;
  logic [6:0]              addr_q;
  logic [7:0]              rd_sh_q;
  logic                    sdo_q;
  logic                    oe_q;
  cssr_pkg::cssr_wr_t      wr_q;
  logic [7:0]              rdata;
  logic                    lat_n_q;
  logic                    ie_q;
  logic                    div_q;
  logic                    synth_lock_restart_q;
  logic                    cal_q;
  logic                    edge_q;
  logic [5:0]              res_q;
  logic [5:0]              man_q;
  logic                    man_en_q;
  logic                    out_edge;
  // Pin synchronisers
  always_ff @(posedge clock) begin
    if (!nrst) begin
      sclk_s_q <= 3'h0;
      cs_s_q   <= 2'h3;
      sdi_s_q  <= 2'h0;
    end else begin
      sclk_s_q <= {sclk_s_q[1:0], spi_sclk};
      cs_s_q   <= {cs_s_q[0], spi_cs_n};
      sdi_s_q  <= {sdi_s_q[0], spi_sdi};
    end
  end

  // Status input synchronisers
  always_ff @(posedge clock) begin
    if (!nrst) begin
      st1_q <= '0;
      st_q  <= '0;
    end else begin
      st1_q <= stat_in;
      st_q  <= st1_q;
    end
  end

  assign rise   = sclk_s_q[1] && !sclk_s_q[2];
  assign fall   = !sclk_s_q[1] && sclk_s_q[2];
  assign cs_act = !cs_s_q[1];
  assign sdi    = sdi_s_q[1];
  // Frame sequencer
  always_ff @(posedge clock) begin
    if (!nrst) begin
      state_q <= cssr_pkg::CSSR_IDLE;
    end else if (!cs_act) begin
      state_q <= cssr_pkg::CSSR_IDLE;
    end else begin
      case (state_q)
        cssr_pkg::CSSR_IDLE: begin
          state_q <= cssr_pkg::CSSR_HEAD;
        end
        cssr_pkg::CSSR_HEAD: begin
          if (rise && cnt_q == `CSSR_CNT_ADDR) begin
            state_q <= cssr_pkg::CSSR_BODY;
          end
        end
        cssr_pkg::CSSR_BODY: begin
          if (rise && cnt_q == `CSSR_CNT_LAST) begin
            state_q <= cssr_pkg::CSSR_END;
          end
        end
        cssr_pkg::CSSR_END: begin
          state_q <= cssr_pkg::CSSR_END;
        end
        default: begin
          state_q <= cssr_pkg::CSSR_IDLE;
        end
      endcase
    end
  end

  // Bit counter and input shifter
  always_ff @(posedge clock) begin
    if (!nrst || !cs_act) begin
      cnt_q <= 5'h00;
      sh_q  <= 7'h00;
    end else if (rise && cnt_q != `CSSR_CNT_DONE) begin
      cnt_q <= cnt_q + 5'h01;
      sh_q  <= {sh_q[5:0], sdi};
    end
  end

  // Header capture
  always_ff @(posedge clock) begin
    if (!nrst) begin
      rd_q   <= 1'b0;
      addr_q <= 7'h00;
    end else if (rise && state_q == cssr_pkg::CSSR_HEAD && cnt_q == `CSSR_CNT_ADDR) begin
      rd_q   <= sh_q[6];
      addr_q <= {sh_q[5:0], sdi};
    end
  end

  // Write commit on the last data bit
  always_ff @(posedge clock) begin
    if (!nrst) begin
      wr_q <= '0;
    end else begin
      wr_q.stb  <= rise && state_q == cssr_pkg::CSSR_BODY && cnt_q == `CSSR_CNT_LAST && !rd_q;
      wr_q.addr <= addr_q;
      wr_q.data <= {sh_q, sdi};
    end
  end

  // Read data mux
  always_comb begin
    rdata = 8'h00;
    case ({sh_q[5:0], sdi})
      `CSSR_A_BIAS_RES: begin
        rdata[`CSSR_BIAS_W-1:0] = res_q;
      end
      `CSSR_A_CAL_EDGE: begin
        rdata[`CSSR_B_EDGE] = edge_q;
      end
      `CSSR_A_BIAS_MAN: begin
        rdata[`CSSR_B_MAN_HI:`CSSR_B_MAN_LO] = man_q;
        rdata[`CSSR_B_MAN_EN] = man_en_q;
      end
      `CSSR_A_STATUS: begin
        rdata[`CSSR_B_LAT] = lat_n_q;
        rdata[`CSSR_B_NOW] = !st_q.holdover_state;
        rdata[`CSSR_B_REF] = st_q.ref_present;
        rdata[`CSSR_B_CAL] = st_q.synth_cal_active;
        rdata[`CSSR_B_IE]  = ie_q;
      end
      default: begin
        rdata = 8'h00;
      end
    endcase
  end
  assign out_edge = edge_q ? rise : fall;
  // Read data shifter and output
  always_ff @(posedge clock) begin
    if (!nrst || !cs_act) begin
      rd_sh_q <= 8'h00;
      sdo_q   <= 1'b0;
      oe_q    <= 1'b0;
    end else if (rise && state_q == cssr_pkg::CSSR_HEAD && cnt_q == `CSSR_CNT_ADDR) begin
      oe_q <= sh_q[6];
      if (edge_q) begin
        sdo_q   <= rdata[7];
        rd_sh_q <= {rdata[6:0], 1'b0};
      end else begin
        rd_sh_q <= rdata;
      end
    end else if (out_edge && state_q == cssr_pkg::CSSR_BODY && cnt_q >= `CSSR_CNT_DATA) begin
      sdo_q   <= rd_sh_q[7];
      rd_sh_q <= {rd_sh_q[6:0], 1'b0};
    end
  end

  assign spi_sdo    = sdo_q;
  assign spi_sdo_oe = oe_q;

  // Latched holdover flag, entry wins over clear
  always_ff @(posedge clock) begin
    if (!nrst) begin
      lat_n_q <= `CSSR_LAT_RST;
    end else if (st_q.holdover_state) begin
      lat_n_q <= 1'b0;
    end else if (wr_hit(wr_q, `CSSR_A_STATUS, `CSSR_B_LAT)) begin
      lat_n_q <= 1'b1;
    end
  end

  // Holdover interrupt enable
  always_ff @(posedge clock) begin
    if (!nrst) begin
      ie_q <= 1'b0;
    end else if (wr_q.stb && wr_q.addr == `CSSR_A_STATUS) begin
      ie_q <= wr_q.data[`CSSR_B_IE];
    end
  end
  assign alert_out_n = !(ie_q && !lat_n_q);
  // Self-clearing command pulses
  always_ff @(posedge clock) begin
    if (!nrst) begin
      div_q    <= 1'b0;
      synth_lock_restart_q <= 1'b0;
    end else begin
      div_q    <= wr_hit(wr_q, `CSSR_A_DIV_INIT, `CSSR_B_CMD);
      synth_lock_restart_q <= wr_hit(wr_q, `CSSR_A_SYNTH_LOCK_RESTART, `CSSR_B_CMD);
    end
  end

  // Bias calibration request, new start wins over done
  always_ff @(posedge clock) begin
    if (!nrst) begin
      cal_q <= 1'b0;
    end else if (wr_hit(wr_q, `CSSR_A_CAL_EDGE, `CSSR_B_CMD)) begin
      cal_q <= 1'b1;
    end else if (bias_cal_done) begin
      cal_q <= 1'b0;
    end
  end

  // Readback edge select
  always_ff @(posedge clock) begin
    if (!nrst) begin
      edge_q <= `CSSR_EDGE_RST;
    end else if (wr_q.stb && wr_q.addr == `CSSR_A_CAL_EDGE) begin
      edge_q <= wr_q.data[`CSSR_B_EDGE];
    end
  end

  // Calibrated bias result
  always_ff @(posedge clock) begin
    if (!nrst) begin
      res_q <= `CSSR_BIAS_RST;
    end else if (bias_cal_done) begin
      res_q <= bias_cal_value;
    end
  end

  // Manual bias override
  always_ff @(posedge clock) begin
    if (!nrst) begin
      man_q    <= `CSSR_BIAS_RST;
      man_en_q <= 1'b0;
    end else if (wr_q.stb && wr_q.addr == `CSSR_A_BIAS_MAN) begin
      man_q    <= wr_q.data[`CSSR_B_MAN_HI:`CSSR_B_MAN_LO];
      man_en_q <= wr_q.data[`CSSR_B_MAN_EN];
    end
  end

  assign bias_effective     = man_en_q ? man_q : res_q;
  assign divider_init       = div_q;
  assign synth_lock_restart = synth_lock_restart_q;
  assign bias_cal_start     = cal_q;
  assign readback_edge_sel  = edge_q;
  property p_lat_set;
    @(posedge clock) disable iff (!nrst) st_q.holdover_state |=> !lat_n_q;
  endproperty
  a_lat_set: assert property (p_lat_set) else $error("latch not set");
  property p_lat_clr;
    @(posedge clock) disable iff (!nrst)
    wr_hit(wr_q, `CSSR_A_STATUS, `CSSR_B_LAT) && !st_q.holdover_state |=> lat_n_q ##0 alert_out_n;
  endproperty
  a_lat_clr: assert property (p_lat_clr) else $error("latch not cleared");
  property p_alert;
    @(posedge clock) disable iff (!nrst)
    st_q.holdover_state && ie_q && !wr_q.stb |=> !alert_out_n;
  endproperty
  a_alert: assert property (p_alert) else $error("alert not raised");
  property p_div;
    @(posedge clock) disable iff (!nrst)
    wr_hit(wr_q, `CSSR_A_DIV_INIT, `CSSR_B_CMD) |=> divider_init ##1 !divider_init;
  endproperty
  a_div: assert property (p_div) else $error("divider init pulse wrong");
  property p_synth_lock_restart;
    @(posedge clock) disable iff (!nrst)
    synth_lock_restart |-> $past(wr_q.stb) && $past(wr_q.addr) == `CSSR_A_SYNTH_LOCK_RESTART;
  endproperty
  a_synth_lock_restart: assert property (p_synth_lock_restart) else $error("synth_lock_restart without write");
  property p_cal;
    @(posedge clock) disable iff (!nrst)
    bias_cal_start && bias_cal_done && !wr_q.stb |=> !bias_cal_start;
  endproperty
  a_cal: assert property (p_cal) else $error("bias cal did not clear");
  property p_edge;
    @(posedge clock) disable iff (!nrst)
    wr_q.stb && wr_q.addr == `CSSR_A_CAL_EDGE |=> readback_edge_sel == $past(wr_q.data[`CSSR_B_EDGE]);
  endproperty
  a_edge: assert property (p_edge) else $error("edge select not stored");
  property p_res;
    @(posedge clock) disable iff (!nrst)
    bias_cal_done ##1 !man_en_q |-> bias_effective == $past(bias_cal_value);
  endproperty
  a_res: assert property (p_res) else $error("bias result not used");
  property p_man;
    @(posedge clock) disable iff (!nrst)
    man_en_q && $stable(man_q) |-> bias_effective == $past(man_q);
  endproperty
  a_man: assert property (p_man) else $error("manual bias not used");
endmodule
`default_nettype wire

// ===== sim/cssr_host.sv
// Host model: serial port master for the register bank
`timescale 1ns/100ps
`default_nettype none
module cssr_host (
  input  wire logic  clock,
  input  wire logic  spi_sdo,
  output logic       spi_sclk,
  output logic       spi_cs_n,
  output logic       spi_sdi,
  output logic       rd_stb,
  output logic [7:0] rd_data
);
  logic pol;
  initial begin
    spi_sclk = 1'b0;
    spi_cs_n = 1'b1;
    spi_sdi  = 1'b0;
    rd_stb   = 1'b0;
    rd_data  = 8'h00;
    pol      = 1'b0;
  end
  task automatic half();
    repeat (8) @(negedge clock);
  endtask
  // One frame, first bit sent is read/write, then address and data
  task automatic xfer(input logic rd, input logic [6:0] a, input logic [7:0] d, input int nb);
    logic [15:0] f;
    f = {rd, a, d};
    @(negedge clock);
    spi_cs_n = 1'b0;
    for (int i = 0; i < nb; i++) begin
      spi_sdi = f[15 - i];
      half();
      if (!pol && i >= 8) rd_data[15 - i] = spi_sdo;
      spi_sclk = 1'b1;
      half();
      if (pol && i >= 7 && i < 15) rd_data[14 - i] = spi_sdo;
      spi_sclk = 1'b0;
    end
    half();
    spi_cs_n = 1'b1;
    spi_sdi  = ~spi_sdi;
    if (!rd && nb == 16 && a == 7'h57) pol = d[0];
    if (rd && nb == 16) begin
      rd_stb = 1'b1;
      @(negedge clock);
      rd_stb = 1'b0;
    end
    repeat (4) @(negedge clock);
  endtask
endmodule
`default_nettype wire

// ===== sim/cssr_regs_tb.sv
// Self-checking bench for the status/control register bank
`timescale 1ns/100ps
`default_nettype none
module cssr_regs_tb;
  logic                 clock, nrst, sclk, cs_n, sdi, sdo, sdo_oe, rd_stb;
  logic                 cal_done, div, rl, cal_start, edge_sel, alert_n;
  logic [5:0]           cal_val, bias_eff, v, m;
  logic [7:0]           rd_data;
  logic [7:0]           exp_q[$];
  cssr_pkg::cssr_stat_t stat;
  int                   fail_count, comparisons, cycles, div_n, rl_n, oe_n, oe_base;

  initial clock = 1'b0;
  always #2.5 clock = ~clock;

  cssr_regs DUT (.clock(clock), .nrst(nrst), .spi_sclk(sclk), .spi_cs_n(cs_n),
    .spi_sdi(sdi), .spi_sdo(sdo), .spi_sdo_oe(sdo_oe), .stat_in(stat),
    .bias_cal_done(cal_done), .bias_cal_value(cal_val), .divider_init(div),
    .synth_lock_restart(rl), .bias_cal_start(cal_start),
    .readback_edge_sel(edge_sel), .bias_effective(bias_eff), .alert_out_n(alert_n));
  cssr_host host (.clock(clock), .spi_sdo(sdo), .spi_sclk(sclk), .spi_cs_n(cs_n),
    .spi_sdi(sdi), .rd_stb(rd_stb), .rd_data(rd_data));

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    host.xfer(1'b0, a, d, 16);
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    host.xfer(1'b1, a, 8'h00, 16);
  endtask
  function automatic logic [7:0] st(input logic lat, input logic ie);
    return {3'b000, ie, stat.synth_cal_active, stat.ref_present, ~stat.holdover_state, lat};
  endfunction

  // Result watcher and timeout
  always @(posedge clock) begin
    cycles++;
    if (div === 1'b1) div_n++;
    if (rl === 1'b1) rl_n++;
    if (sdo_oe === 1'b1) oe_n++;
    if (rd_stb === 1'b1) begin
      check(rd_data, exp_q.pop_front());
    end
    if (cycles == 40000) begin
      fail_count++;
      summarize();
    end
  end

  initial begin
    nrst = 1'b0;
    stat = 3'b011;
    cal_done = 1'b0;
    cal_val = 6'h00;
    void'($urandom(32'h5585220c));
    repeat (20) @(negedge clock);
    nrst = 1'b1;
    repeat (4) @(negedge clock);
    check({7'h00, alert_n}, 8'h01);
    check({2'b00, bias_eff}, 8'h00);
    rd(7'h63, 8'h00);
    rd(7'h57, 8'h00);
    rd(7'h5A, st(1'b1, 1'b0));
    check({7'h00, oe_n != 0}, 8'h01);
    oe_base = oe_n;
    // Startup commands
    wr(7'h55, 8'h80);
    check(div_n[7:0], 8'h01);
    check(8'(oe_n - oe_base), 8'h00);
    wr(7'h57, 8'h80);
    v = 6'($urandom);
    repeat (10) @(negedge clock);
    check({7'h00, cal_start}, 8'h01);
    cal_val = v;
    cal_done = 1'b1;
    @(negedge clock);
    cal_done = 1'b0;
    cal_val = ~v;
    repeat (3) @(negedge clock);
    check({7'h00, cal_start}, 8'h00);
    rd(7'h4E, {2'b00, v});
    wr(7'h4E, 8'hFF);
    rd(7'h4E, {2'b00, v});
    check({2'b00, bias_eff}, {2'b00, v});
    wr(7'h56, 8'h00);
    wr(7'h56, 8'h80);
    check(rl_n[7:0], 8'h01);
    // Manual bias, reserved bit and aborted frame
    m = 6'($urandom) & 6'h3E;
    wr(7'h63, {1'b1, m, 1'b1});
    rd(7'h63, {1'b0, m, 1'b1});
    check({2'b00, bias_eff}, {2'b00, m});
    host.xfer(1'b0, 7'h63, 8'h00, 10);
    rd(7'h63, {1'b0, m, 1'b1});
    wr(7'h63, {1'b0, m, 1'b0});
    check({2'b00, bias_eff}, {2'b00, v});
    // Rising-edge readback
    wr(7'h57, 8'h01);
    check({7'h00, edge_sel}, 8'h01);
    rd(7'h57, 8'h01);
    rd(7'h63, {1'b0, m, 1'b0});
    wr(7'h57, 8'h00);
    rd(7'h10, 8'h00);
    // Holdover latch with alert enabled
    wr(7'h5A, 8'h10);
    stat.holdover_state = 1'b1;
    rd(7'h5A, st(1'b0, 1'b1));
    check({7'h00, alert_n}, 8'h00);
    stat.holdover_state = 1'b0;
    rd(7'h5A, st(1'b0, 1'b1));
    wr(7'h5A, 8'h11);
    check({7'h00, alert_n}, 8'h01);
    rd(7'h5A, st(1'b1, 1'b1));
    // Alert disabled
    wr(7'h5A, 8'h00);
    stat.holdover_state = 1'b1;
    repeat (6) @(negedge clock);
    check({7'h00, alert_n}, 8'h01);
    stat.holdover_state = 1'b0;
    wr(7'h5A, 8'h01);
    for (int i = 0; i < 4; i++) begin
      stat.ref_present = 1'($urandom);
      stat.synth_cal_active = 1'(i);
      rd(7'h5A, st(1'b1, 1'b0));
    end
    summarize();
  end
endmodule
`default_nettype wire
